/* core/scd_decoder.sv */
// Segment control word decoder and segment sequencer, AXI4-Lite slave.
// Assumes one clock, a planner on the same clock, one access at a time.
//
// Design decision made here: the AXI4-Lite interface to the registers.

`timescale 1ns/1ps
`default_nettype none

module scd_decoder
  import scd_pkg::*;
#(
  parameter int SEG_CNT = 31,
  parameter int ADDR_W  = 14
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic      [1:0]        s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic      [31:0]       s_axi_rdata,
  output logic      [1:0]        s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              plan_decel_point,
  input  wire logic              plan_stopped,
  output logic                   cmd_valid,
  output logic      [SEG_W-1:0]  cmd_segment,
  output logic      [1:0]        cmd_mode,
  output logic      [3:0]        cmd_behavior,
  output logic                   cmd_interrupt,
  output logic                   cmd_overlap,
  output logic                   cmd_from_speed,
  output logic                   cmd_carry_remain,
  output logic                   cmd_unit_pps,
  output logic                   cmd_is_speed,
  output logic      [31:0]       cmd_operand,
  output logic      [TBL_W-1:0]  cmd_accel_time,
  output logic      [TBL_W-1:0]  cmd_decel_time,
  output logic      [TBL_W-1:0]  cmd_run_speed,
  output logic      [TBL_W-1:0]  cmd_dwell_time,
  output logic                   seq_busy
);

  // ********************************
  // Access decode helpers
  // ********************************
  function automatic logic [2:0] kind_of(input logic [11:0] idx);
    logic [11:0] rel;
    rel = idx - IDX_CTRL_BASE;
    kind_of = K_NONE;
    if (idx >= IDX_CTRL_BASE && rel < 12'(SEG_CNT * 4)) begin
      if (rel[1:0] == 2'h0) kind_of = K_CTRL;
      else if (rel[1:0] == OPER_LANE) kind_of = K_OPER;
    end
    else if (idx >= IDX_RAMP_FIRST && idx <= IDX_RAMP_LAST) kind_of = K_RAMP;
    else if (idx >= IDX_SPD_FIRST && idx <= IDX_SPD_LAST) kind_of = K_SPD;
    else if (idx >= IDX_DWELL_FIRST && idx <= IDX_DWELL_LAST) begin
      kind_of = K_DWELL;
    end
    else if (idx == IDX_RUN_CTL) kind_of = K_RUN;
    else if (idx == IDX_STATUS) kind_of = K_STAT;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    for (int b = 0; b < 4; b++) begin
      merge[8*b +: 8] = strb[b] ? nw[8*b +: 8] : old[8*b +: 8];
    end
  endfunction

  // ********************************
  // State declarations
  // ********************************
  logic [31:0]               ctrl_r [SEG_CNT];
  logic [31:0]               ctrl_nxt [SEG_CNT];
  logic [31:0]               oper_r [SEG_CNT];
  logic [31:0]               oper_nxt [SEG_CNT];
  logic [SLOT_N-1:0][TBL_W-1:0] ramp_r, ramp_nxt, spd_r, spd_nxt;
  logic [SLOT_N-1:0][TBL_W-1:0] dwell_r, dwell_nxt;
  logic                      aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
  logic [11:0]               aw_idx_r, aw_idx_nxt, r_idx;
  logic [31:0]               w_data_r, w_data_nxt, rdata_nxt;
  logic [3:0]                w_strb_r, w_strb_nxt;
  logic                      bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0]                bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0]               rdata_r;
  logic                      go_r, go_nxt;
  logic [SEG_W-1:0]          go_seg_r, go_seg_nxt;
  logic                      wr_fire, go_ok;
  logic [2:0]                w_kind, r_kind;
  logic [11:0]               w_rel, r_rel;
  scd_state_t                st_r, st_nxt;
  logic [SEG_W-1:0]          seg_r, seg_nxt, pend_seg_r, pend_seg_nxt;
  logic                      pend_r, pend_nxt, from_r, from_nxt;
  logic                      carry_r, carry_nxt, issue, done_evt;
  logic [31:0]               cur_ctrl, cur_oper;
  logic [1:0]                d_mode;
  logic                      d_pos, d_spd, d_ovl, d_pps;
  logic [TBL_W-1:0]          d_acc, d_dec, d_run, d_dly;

  // ********************************
  // AXI4-Lite channel logic
  // ********************************
  assign s_axi_awready = !aw_hold_r && !bvalid_r;
  assign s_axi_wready  = !w_hold_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rresp   = rresp_r;
  assign s_axi_rdata   = rdata_r;
  assign wr_fire = aw_hold_r && w_hold_r && !bvalid_r;
  assign w_kind  = kind_of(aw_idx_r);
  assign w_rel   = aw_idx_r - IDX_CTRL_BASE;
  assign r_idx   = s_axi_araddr[13:2];
  assign r_kind  = kind_of(r_idx);
  assign r_rel   = r_idx - IDX_CTRL_BASE;

  always_comb begin
    aw_hold_nxt = aw_hold_r;
    aw_idx_nxt  = aw_idx_r;
    w_hold_nxt  = w_hold_r;
    w_data_nxt  = w_data_r;
    w_strb_nxt  = w_strb_r;
    bvalid_nxt  = bvalid_r && !s_axi_bready;
    bresp_nxt   = bresp_r;
    rvalid_nxt  = rvalid_r && !s_axi_rready;
    rresp_nxt   = rresp_r;
    rdata_nxt   = rdata_r;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_nxt = 1'b1;
      aw_idx_nxt  = s_axi_awaddr[13:2];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_hold_nxt = 1'b1;
      w_data_nxt = s_axi_wdata;
      w_strb_nxt = s_axi_wstrb;
    end
    if (wr_fire) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = (w_kind == K_NONE || w_kind == K_STAT) ?
                    RESP_SLVERR : RESP_OKAY;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = RESP_OKAY;
      case (r_kind)
        K_CTRL:  rdata_nxt = ctrl_r[r_rel[SEG_W+1:2]];
        K_OPER:  rdata_nxt = oper_r[r_rel[SEG_W+1:2]];
        K_RAMP:  rdata_nxt = {16'h0, ramp_r[r_idx[2:0]]};
        K_SPD:   rdata_nxt = {16'h0, spd_r[r_idx[2:0]]};
        K_DWELL: rdata_nxt = {16'h0, dwell_r[r_idx[2:0]]};
        K_RUN:   rdata_nxt = {27'h0, go_seg_r};
        K_STAT: begin
          rdata_nxt = 32'h0;
          rdata_nxt[STAT_BUSY] = (st_r != S_IDLE);
          rdata_nxt[STAT_SEG +: SEG_W] = seg_r;
          rdata_nxt[STAT_PEND] = pend_r;
        end
        default: begin
          rdata_nxt = 32'h0;
          rresp_nxt = RESP_SLVERR;
        end
      endcase
    end
  end

  // ********************************
  // Register file writes
  // ********************************
  always_comb begin
    ctrl_nxt   = ctrl_r;
    oper_nxt   = oper_r;
    ramp_nxt   = ramp_r;
    spd_nxt    = spd_r;
    dwell_nxt  = dwell_r;
    go_nxt     = 1'b0;
    go_seg_nxt = go_seg_r;
    if (wr_fire) begin
      case (w_kind)
        K_CTRL: ctrl_nxt[w_rel[SEG_W+1:2]] =
          merge(ctrl_r[w_rel[SEG_W+1:2]], w_data_r, w_strb_r);
        K_OPER: oper_nxt[w_rel[SEG_W+1:2]] =
          merge(oper_r[w_rel[SEG_W+1:2]], w_data_r, w_strb_r);
        K_RAMP: if (&w_strb_r[1:0]) ramp_nxt[aw_idx_r[2:0]] = w_data_r[15:0];
        K_SPD: if (&w_strb_r[1:0]) spd_nxt[aw_idx_r[2:0]] = w_data_r[15:0];
        K_DWELL: begin
          if (&w_strb_r[1:0]) dwell_nxt[aw_idx_r[2:0]] = w_data_r[15:0];
        end
        K_RUN: begin
          if (w_strb_r[0]) go_seg_nxt = w_data_r[SEG_W-1:0];
          go_nxt = w_strb_r[1] && w_data_r[RUN_GO_BIT];
        end
        default: go_nxt = 1'b0;
      endcase
    end
  end

  // ********************************
  // Control word decode
  // ********************************
  assign cur_ctrl = ctrl_r[seg_r];
  assign cur_oper = oper_r[seg_r];
  assign d_mode   = cur_ctrl[FLD_MODE +: 2];
  assign d_pos    = (d_mode == MODE_SINGLE) || (d_mode == MODE_MULTI);
  assign d_spd    = (d_mode == MODE_SPEED);
  assign d_ovl    = (d_mode == MODE_MULTI) && cur_ctrl[FLD_OVL];
  assign d_pps    = d_spd && cur_ctrl[FLD_OVL];

  scd_slot_select #(.W(TBL_W), .N(SLOT_N)) u_acc (
    .sel      (cur_ctrl[FLD_ACC +: SEL_W]),
    .en       (d_pos || d_spd),
    .table_in (ramp_r),
    .value    (d_acc)
  );
  scd_slot_select #(.W(TBL_W), .N(SLOT_N)) u_dec (
    .sel      (cur_ctrl[FLD_DEC +: SEL_W]),
    .en       (d_pos || d_spd),
    .table_in (ramp_r),
    .value    (d_dec)
  );
  scd_slot_select #(.W(TBL_W), .N(SLOT_N)) u_run (
    .sel      (cur_ctrl[FLD_SPD +: SEL_W]),
    .en       (d_pos),
    .table_in (spd_r),
    .value    (d_run)
  );
  scd_slot_select #(.W(TBL_W), .N(SLOT_N)) u_dly (
    .sel      (cur_ctrl[FLD_DLY +: SEL_W]),
    .en       ((d_pos || d_spd) && !d_ovl),
    .table_in (dwell_r),
    .value    (d_dly)
  );

  // ********************************
  // Segment sequencer
  // ********************************
  assign go_ok = go_r && (32'(go_seg_r) < SEG_CNT);
  assign seq_busy = (st_r != S_IDLE);

  always_comb begin
    st_nxt       = st_r;
    seg_nxt      = seg_r;
    pend_nxt     = pend_r;
    pend_seg_nxt = pend_seg_r;
    from_nxt     = from_r;
    carry_nxt    = carry_r;
    issue        = 1'b0;
    done_evt     = 1'b0;
    case (st_r)
      S_IDLE: begin
        if (go_ok) begin
          seg_nxt   = go_seg_r;
          from_nxt  = 1'b0;
          carry_nxt = 1'b0;
          st_nxt    = S_ISSUE;
        end
      end
      S_ISSUE: begin
        if (d_mode == MODE_JUMP) begin
          seg_nxt = cur_oper[SEG_W-1:0];
          if (32'(cur_oper[SEG_W-1:0]) >= SEG_CNT) st_nxt = S_IDLE;
        end
        else begin
          issue  = 1'b1;
          st_nxt = S_RUN;
        end
      end
      S_RUN: begin
        case (cmd_mode)
          MODE_SINGLE: done_evt = plan_stopped;
          MODE_MULTI: done_evt = cmd_overlap ? plan_decel_point
                                             : plan_stopped;
          MODE_SPEED: done_evt = plan_stopped && (cmd_behavior == BEHV_AUTO);
          default: done_evt = 1'b0;
        endcase
        if (go_ok && (cmd_interrupt || cmd_mode == MODE_SPEED)) begin
          seg_nxt   = go_seg_r;
          carry_nxt = cmd_interrupt;
          from_nxt  = 1'b0;
          pend_nxt  = 1'b0;
          st_nxt    = S_ISSUE;
        end
        else if (done_evt) begin
          from_nxt  = cmd_overlap;
          carry_nxt = 1'b0;
          pend_nxt  = 1'b0;
          st_nxt    = S_ISSUE;
          if (go_ok) seg_nxt = go_seg_r;
          else if (pend_r) seg_nxt = pend_seg_r;
          else if (cmd_mode == MODE_SINGLE ||
                   32'(seg_r) + 1 >= SEG_CNT) st_nxt = S_IDLE;
          else seg_nxt = seg_r + 1'b1;
        end
        else if (go_ok) begin
          pend_nxt     = 1'b1;
          pend_seg_nxt = go_seg_r;
        end
      end
      default: st_nxt = S_IDLE;
    endcase
  end

  // ********************************
  // Registers
  // ********************************
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      for (int i = 0; i < SEG_CNT; i++) begin
        ctrl_r[i] <= RST_CTRL;
        oper_r[i] <= RST_OPER;
      end
      for (int i = 0; i < SLOT_N; i++) begin
        ramp_r[i]  <= RST_RAMP[i];
        spd_r[i]   <= RST_SPD;
        dwell_r[i] <= RST_DWELL;
      end
      aw_hold_r <= 1'b0;
      aw_idx_r  <= 12'h0;
      w_hold_r  <= 1'b0;
      w_data_r  <= 32'h0;
      w_strb_r  <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      rvalid_r  <= 1'b0;
      rresp_r   <= RESP_OKAY;
      rdata_r   <= 32'h0;
      go_r      <= 1'b0;
      go_seg_r  <= '0;
      st_r      <= S_IDLE;
      seg_r     <= '0;
      pend_r    <= 1'b0;
      pend_seg_r <= '0;
      from_r    <= 1'b0;
      carry_r   <= 1'b0;
      cmd_valid <= 1'b0;
      cmd_segment <= '0;
      cmd_mode  <= MODE_SINGLE;
      cmd_behavior <= 4'h0;
      cmd_interrupt <= 1'b0;
      cmd_overlap <= 1'b0;
      cmd_from_speed <= 1'b0;
      cmd_carry_remain <= 1'b0;
      cmd_unit_pps <= 1'b0;
      cmd_is_speed <= 1'b0;
      cmd_operand <= 32'h0;
      cmd_accel_time <= '0;
      cmd_decel_time <= '0;
      cmd_run_speed <= '0;
      cmd_dwell_time <= '0;
    end
    else begin
      ctrl_r <= ctrl_nxt;
      oper_r <= oper_nxt;
      ramp_r <= ramp_nxt;
      spd_r <= spd_nxt;
      dwell_r <= dwell_nxt;
      aw_hold_r <= aw_hold_nxt;
      aw_idx_r <= aw_idx_nxt;
      w_hold_r <= w_hold_nxt;
      w_data_r <= w_data_nxt;
      w_strb_r <= w_strb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
      go_r <= go_nxt;
      go_seg_r <= go_seg_nxt;
      st_r <= st_nxt;
      seg_r <= seg_nxt;
      pend_r <= pend_nxt;
      pend_seg_r <= pend_seg_nxt;
      from_r <= from_nxt;
      carry_r <= carry_nxt;
      cmd_valid <= issue;
      if (issue) begin
        cmd_segment <= seg_r;
        cmd_mode <= d_mode;
        cmd_behavior <= cur_ctrl[FLD_BEHV +: NIB_W];
        cmd_interrupt <= cur_ctrl[FLD_INTR];
        cmd_overlap <= d_ovl;
        cmd_from_speed <= from_r;
        cmd_carry_remain <= carry_r;
        cmd_unit_pps <= d_pps;
        cmd_is_speed <= d_spd;
        cmd_operand <= cur_oper;
        cmd_accel_time <= d_acc;
        cmd_decel_time <= d_dec;
        cmd_run_speed <= d_run;
        cmd_dwell_time <= d_dly;
      end
    end
  end

  // ********************************
  // Assertions
  // ********************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_run_idle_planner;
    (st_r == S_RUN) && !go_ok;
  endsequence
  sequence s_reissue_from_speed;
    (st_r == S_ISSUE) && from_r;
  endsequence

  a_single_no_ovl: assert property (
    cmd_valid && cmd_mode == MODE_SINGLE |-> !cmd_overlap)
    else $error("overlap set on single segment");
  a_ovl_dwell_zero: assert property (
    cmd_valid && cmd_overlap |-> cmd_dwell_time == '0)
    else $error("dwell not zero under overlap");
  a_unit_speed_only: assert property (
    cmd_valid && cmd_unit_pps |-> cmd_mode == MODE_SPEED && cmd_is_speed)
    else $error("speed unit outside speed mode");
  a_jump_not_issued: assert property (
    cmd_valid |-> cmd_mode != MODE_JUMP)
    else $error("jump segment issued to planner");
  a_speed_run_zero: assert property (
    cmd_valid && cmd_mode == MODE_SPEED |-> cmd_run_speed == '0)
    else $error("run speed used in speed mode");
  a_ovl_advance: assert property (
    s_run_idle_planner ##0 (cmd_mode == MODE_MULTI && cmd_overlap &&
    plan_decel_point) |=> s_reissue_from_speed)
    else $error("overlap did not advance at decel point");
  a_no_ovl_waits: assert property (
    s_run_idle_planner ##0 (cmd_mode == MODE_MULTI && !cmd_overlap &&
    !plan_stopped) |=> st_r == S_RUN)
    else $error("segment left before stop");
  a_intr_switch: assert property (
    st_r == S_RUN && go_ok && cmd_interrupt |=>
    (st_r == S_ISSUE) && carry_r && (seg_r == $past(go_seg_r)))
    else $error("interrupt did not switch at once");
  a_keep_settings: assert property (
    s_run_idle_planner ##0 !plan_decel_point && !plan_stopped |=>
    $stable(cmd_accel_time) && $stable(cmd_operand) && !cmd_valid)
    else $error("settings changed before decel point");

endmodule

`default_nettype wire

/* core/scd_pkg.sv */
// Constants shared by the segment control word decoder.
// Assumes register indices are word indices on an AXI4-Lite bus.

package scd_pkg;

  // ********************************
  // Segment table geometry
  // ********************************
  localparam int SEG_W = 5;
  localparam int TBL_W = 16;
  localparam int SLOT_N = 8;

  // ********************************
  // Register indices (byte address is four times the index)
  // ********************************
  localparam logic [11:0] IDX_CTRL_BASE   = 12'h804;
  localparam logic [11:0] IDX_OPER_BASE   = 12'h806;
  localparam logic [11:0] SEG_STRIDE      = 12'h004;
  localparam logic [1:0]  OPER_LANE       = 2'h2;
  localparam logic [11:0] IDX_RAMP_FIRST  = 12'h880;
  localparam logic [11:0] IDX_RAMP_LAST   = 12'h887;
  localparam logic [11:0] IDX_SPD_FIRST   = 12'h888;
  localparam logic [11:0] IDX_SPD_LAST    = 12'h88f;
  localparam logic [11:0] IDX_DWELL_FIRST = 12'h890;
  localparam logic [11:0] IDX_DWELL_LAST  = 12'h897;
  localparam logic [11:0] IDX_RUN_CTL     = 12'h8a0;
  localparam logic [11:0] IDX_STATUS      = 12'h8a1;

  // ********************************
  // Decoded access kinds
  // ********************************
  localparam logic [2:0] K_NONE  = 3'h0;
  localparam logic [2:0] K_CTRL  = 3'h1;
  localparam logic [2:0] K_OPER  = 3'h2;
  localparam logic [2:0] K_RAMP  = 3'h3;
  localparam logic [2:0] K_SPD   = 3'h4;
  localparam logic [2:0] K_DWELL = 3'h5;
  localparam logic [2:0] K_RUN   = 3'h6;
  localparam logic [2:0] K_STAT  = 3'h7;

  // ********************************
  // Control word nibble positions
  // ********************************
  localparam int NIB_W    = 4;
  localparam int SEL_W    = 3;
  localparam int FLD_MODE = 0;
  localparam int FLD_BEHV = 4;
  localparam int FLD_INTR = 8;
  localparam int FLD_OVL  = 12;
  localparam int FLD_ACC  = 16;
  localparam int FLD_DEC  = 20;
  localparam int FLD_SPD  = 24;
  localparam int FLD_DLY  = 28;

  // ********************************
  // Segment modes and behaviour codes
  // ********************************
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_MULTI  = 2'h1;
  localparam logic [1:0] MODE_SPEED  = 2'h2;
  localparam logic [1:0] MODE_JUMP   = 2'h3;
  localparam logic [3:0] BEHV_AUTO   = 4'h1;

  // ********************************
  // Run control and status fields
  // ********************************
  localparam int RUN_GO_BIT  = 8;
  localparam int STAT_BUSY   = 0;
  localparam int STAT_SEG    = 8;
  localparam int STAT_PEND   = 16;

  // ********************************
  // Reset values and bus answers
  // ********************************
  localparam logic [31:0] RST_CTRL = 32'h0;
  localparam logic [31:0] RST_OPER = 32'h0;
  localparam logic [TBL_W-1:0] RST_SPD   = 16'h0;
  localparam logic [TBL_W-1:0] RST_DWELL = 16'h0;
  localparam logic [TBL_W-1:0] RST_RAMP [SLOT_N] = '{
    16'h0064, 16'h00c8, 16'h012c, 16'h0190,
    16'h01f4, 16'h0000, 16'h0000, 16'h0000};
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {S_IDLE, S_ISSUE, S_RUN} scd_state_t;

endpackage

/* core/scd_slot_select.sv */
// One selector into an eight-slot shared parameter table.
// Assumes the table is held by the caller; output is combinational.

`timescale 1ns/1ps
`default_nettype none

module scd_slot_select #(
  parameter int W = 16,
  parameter int N = 8
) (
  input  wire logic [$clog2(N)-1:0] sel,
  input  wire logic                 en,
  input  wire logic [N-1:0][W-1:0]  table_in,
  output logic      [W-1:0]         value
);

  // ********************************
  // Slot pick, zero when not used
  // ********************************
  always_comb begin
    value = en ? table_in[sel] : '0;
  end

endmodule

`default_nettype wire

/* test/scd_decoder_test.sv */
// Self-checking bench for the segment control word decoder.
// Assumes scd_pkg, the decoder and the planner model compile first.
`timescale 1ns/1ps
`default_nettype none
module scd_decoder_test
  import scd_pkg::*;
;
  typedef struct packed {logic [11:0] i; logic [31:0] d; logic [31:0] e;}
    scd_row_t;
  logic clk = 1'b0, rst_b = 1'b0, awv = 1'b0, wv = 1'b0, brdy = 1'b0;
  logic arv = 1'b0, rrdy = 1'b0, awr, wr_r, bv, arr, rv, dp, stp, busy;
  logic [13:0] awa = '0, ara = '0;
  logic [31:0] wd = '0, rdat, opd, rd;
  logic [3:0]  ws = '0;
  logic [3:0]  bhv;
  logic [1:0]  bresp, rresp, mode, rs, bs;
  logic        cv, ovl, frm, pps, spd, intr, cry;
  logic [4:0]  seg;
  logic [15:0] acc, dec, run, dwl;
  int          miscompares = 0, n_tests = 0, cyc = 0;
  scd_row_t    rows [5] = '{'{12'h88b, 32'h0001_0333, 32'h333},
    '{12'h895, 32'h555, 32'h555}, '{12'h887, 32'h777, 32'h777},
    '{12'h80a, 32'hffff_fff6, 32'hffff_fff6}, '{12'h805, 32'h1234, 32'h0}};
  scd_decoder u_scd_decoder (.clk(clk), .rst_b(rst_b),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wr_r), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(brdy), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rrdy), .plan_decel_point(dp),
    .plan_stopped(stp), .cmd_valid(cv), .cmd_segment(seg), .cmd_mode(mode),
    .cmd_behavior(bhv), .cmd_interrupt(intr), .cmd_overlap(ovl),
    .cmd_from_speed(frm), .cmd_carry_remain(cry), .cmd_unit_pps(pps),
    .cmd_is_speed(spd), .cmd_operand(opd), .cmd_accel_time(acc),
    .cmd_decel_time(dec), .cmd_run_speed(run), .cmd_dwell_time(dwl),
    .seq_busy(busy));
  scd_plan_model #(.DLY(6)) u_scd_plan_model (.clk(clk), .rst_b(rst_b),
    .cmd_valid(cv), .plan_decel_point(dp), .plan_stopped(stp));
  always #4 clk = ~clk;
  // ****
  // Bus tasks and compare
  // ****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] i, input logic [31:0] d);
    logic a = 1'b1;
    logic w = 1'b1;
    awa <= {i, 2'b00};
    wd <= d;
    ws <= 4'hf;
    awv <= 1'b1;
    wv <= 1'b1;
    while (a || w) begin
      @(posedge clk);
      if (a && awr) awv <= 1'b0;
      if (a && awr) a = 1'b0;
      if (w && wr_r) wv <= 1'b0;
      if (w && wr_r) w = 1'b0;
    end
    brdy <= 1'b1;
    do @(posedge clk); while (!bv);
    bs = bresp;
    brdy <= 1'b0;
  endtask
  task automatic rdr(input logic [11:0] i);
    ara <= {i, 2'b00};
    arv <= 1'b1;
    do @(posedge clk); while (!arr);
    arv <= 1'b0;
    rrdy <= 1'b1;
    do @(posedge clk); while (!rv);
    rrdy <= 1'b0;
    rd = rdat;
    rs = rresp;
  endtask
  task automatic wait_cmd();
    int k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (!cv && k < 300);
    if (cv !== 1'b1) miscompares++;
    if (cv !== 1'b1) $display("ERROR %0t no plan issued", $time);
  endtask
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) miscompares++;
    if (cyc == 20000) summarize();
  end
  // ****
  // Main sequence
  // ****
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    for (int k = 0; k < 8; k++) begin
      rdr(IDX_RAMP_FIRST + 12'(k));
      chk(rd, (k < 5) ? 32'(100 * (k + 1)) : 32'h0);
    end
    rdr(IDX_OPER_BASE);
    chk(rd, 32'h0);
    rdr(12'h8b0);
    chk(32'(rs), 32'(RESP_SLVERR));
    foreach (rows[r]) begin
      wr(rows[r].i, rows[r].d);
      rdr(rows[r].i);
      chk(rd, rows[r].e);
    end
    chk(32'(bs), 32'(RESP_SLVERR));
    wr(12'h804, 32'h5347_1001);
    chk(32'(bs), 32'(RESP_OKAY));
    wr(12'h806, 32'd100);
    wr(12'h808, 32'h5000_1000);
    wr(12'h80c, 32'h0301_1002);
    wr(12'h810, 32'h3);
    wr(12'h812, 32'h1);
    wr(IDX_RUN_CTL, 32'h100);
    wait_cmd();
    chk(32'(mode), 32'h1);
    chk(32'(ovl), 32'h1);
    chk(32'(acc), 32'h777);
    chk(32'(dec), 32'd500);
    chk(32'(run), 32'h333);
    chk(32'(dwl), 32'h0);
    chk(opd, 32'd100);
    wait_cmd();
    chk(32'(seg), 32'h1);
    chk(32'(frm), 32'h1);
    chk(32'(ovl), 32'h0);
    chk(opd, 32'hffff_fff6);
    chk(32'(dwl), 32'h555);
    for (int k = 0; k < 60 && busy; k++) @(posedge clk);
    chk(32'(busy), 32'h0);
    wr(IDX_RUN_CTL, 32'h102);
    wait_cmd();
    chk(32'(spd), 32'h1);
    chk(32'(pps), 32'h1);
    chk(32'(run), 32'h0);
    chk(32'(acc), 32'd200);
    wr(IDX_RUN_CTL, 32'h103);
    wait_cmd();
    chk(32'(seg), 32'h1);
    wr(12'h814, 32'h0000_0111);
    wr(IDX_RUN_CTL, 32'h104);
    wait_cmd();
    chk(32'(seg), 32'h4);
    chk(32'(intr), 32'h1);
    chk(32'(bhv), 32'h1);
    chk(32'(cry), 32'h0);
    wr(IDX_RUN_CTL, 32'h102);
    wait_cmd();
    chk(32'(seg), 32'h2);
    chk(32'(cry), 32'h1);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    chk({30'h0, busy, cv}, 32'h0);
    rst_b <= 1'b1;
    summarize();
  end
endmodule
`default_nettype wire

/* test/scd_plan_model.sv */
// Planner model: pulses the deceleration point, then the stop, per plan.
// Assumes the decoder's clock and synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module scd_plan_model #(
  parameter int DLY = 6
) (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic cmd_valid,
  output logic      plan_decel_point = 1'b0,
  output logic      plan_stopped = 1'b0
);
  // ****
  // Profile timer, restarted by each plan
  // ****
  int cnt = 0;
  always @(posedge clk) begin
    if (!rst_b) begin
      cnt <= 2 * DLY;
    end else if (cmd_valid) begin
      cnt <= 0;
    end else if (cnt < 2 * DLY) begin
      cnt <= cnt + 1;
    end
    plan_decel_point <= rst_b && (cnt == DLY - 1);
    plan_stopped     <= rst_b && (cnt == 2 * DLY - 1);
  end
endmodule
`default_nettype wire
